// File: logic/dmx_data_memory.sv
// operand address resolution, internal data memory and status word of the core
// assumes the core issues one request at a time and sees ready_o before the next
// Notes on behaviour
// RULE1 - external data space reaches 64 K bytes
// RULE2 - high address byte on port two, wide access
// RULE3 - port zero multiplexes address then data, strobes
// RULE4 - three port latch lines page 2 K RAM
// RULE5 - one byte internal address, 384 bytes reach
// RULE6 - high direct is special space, indirect upper
// RULE7 - lowest 32 bytes are four register banks
// RULE8 - bank bits chosen at execution time
// RULE9 - opcode register number plus bank gives address
// RULE10 - 16 bytes above banks hold bits 00-7f
// RULE11 - lower 128 reached direct and indirect
// RULE12 - upper RAM indirect only, when fitted
// RULE13 - special registers reached by direct only
// RULE14 - special registers at multiples of eight bit-addressable
// RULE15 - parity flag tracks accumulator ones count
// RULE16 - status word holds carry, half, banks, flags
// RULE17 - carry is the boolean accumulator
// RULE18 - direct address is the instruction byte
// RULE19 - indirect pointers: stack, reg zero/one, data pointer
// RULE20 - program read address is base plus accumulator
// RULE21 - computed jump is pointer plus accumulator
// RULE22 - accumulator opcodes need no address byte
// RULE23 - parity writes have no lasting effect
`timescale 1ns/10ps
`include "dmx_params.svh"
module dmx_data_memory
	import dmx_pkg::*;
#(
	parameter bit HAS_UPPER_RAM = 1'b1,
	parameter int STROBE_CYCLES = `DMX_XRAM_STROBE
) (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic        req_valid_i,
	input  wire dmx_req_t    req_i,
	input  wire dmx_flags_t  flags_i,
	input  wire logic [15:0] program_counter_i,
	output logic             ready_o,
	output logic             busy_o,
	output logic [7:0]       rdata_o,
	output logic [15:0]      code_addr_o,
	output logic [7:0]       status_word_o,
	output logic [7:0]       muxed_addr_data_port_o,
	output logic             muxed_addr_data_port_oe_o,
	input  wire logic [7:0]  muxed_addr_data_port_i,
	output logic             addr_latch_o,
	output logic             read_strobe_n_o,
	output logic             write_strobe_n_o,
	output logic [7:0]       high_address_port_o
);
	dmx_state_t  state_q;
	logic [7:0]  acc_q;
	logic        par_q;
	logic [7:1]  psw_q;
	logic [7:0]  sp_q;
	logic [15:0] data_pointer_q;
	logic [7:0]  p2_q;
	logic [7:0]  lower_q [0:`DMX_LOWER_SIZE-1];
	logic [7:0]  upper_q [0:`DMX_UPPER_SIZE-1];
	logic        take;
	logic [1:0]  bank;
	logic [7:0]  r0_val;
	logic [7:0]  r1_val;
	logic [7:0]  eaddr;
	logic        is_sfr;
	logic        is_acc;
	logic        is_mem;
	logic        is_x;
	logic        is_code;
	logic [2:0]  bit_pos;
	logic [7:0]  bit_mask;
	logic [7:0]  sfr_val;
	logic [7:0]  rd_byte;
	logic        bit_val;
	logic [7:0]  wr_byte;
	logic        do_wr;
	logic        wr_acc;
	logic        wr_sfr;
	logic        cy_op;
	logic        cy_next;
	dmx_xreq_t   xreq;
	logic        x_done;
	logic [7:0]  x_rdata;

	assign take   = req_valid_i && (state_q == ST_IDLE);
	// RULE8 bank at execution
	assign bank   = psw_q[`DMX_PSW_RS1:`DMX_PSW_RS0];
	// RULE19 register pointers
	assign r0_val = lower_q[{2'b00, bank, 3'b000}];
	assign r1_val = lower_q[{2'b00, bank, 3'b001}];
	// RULE16 status word layout
	assign status_word_o = {psw_q, par_q};

	// every internal address is one byte; the mode decides which 128-byte block it means
	always_comb begin
		eaddr   = 8'h00;
		is_sfr  = 1'b0;
		is_acc  = 1'b0;
		is_mem  = 1'b1;
		bit_pos = 3'h0;
		unique case (req_i.mode)
			// RULE18 direct address byte
			// RULE13 direct reaches specials
			MD_DIRECT: begin
				eaddr  = req_i.addr;
				is_sfr = req_i.addr[7];
			end
			// RULE11 indirect lower block
			// RULE12 indirect reaches upper
			MD_IND_R0: eaddr = r0_val;
			MD_IND_R1: eaddr = r1_val;
			MD_IND_SP: eaddr = sp_q;
			// RULE7 four eight-register banks
			// RULE9 bank plus number
			MD_REG: eaddr = {3'b000, bank, req_i.addr[2:0]};
			// RULE22 implicit accumulator
			MD_ACC: is_acc = 1'b1;
			// RULE10 bit area bytes
			// RULE14 aligned special bits
			MD_BIT: begin
				eaddr   = req_i.addr[7] ? {req_i.addr[7:3], 3'b000}
				                        : (`DMX_BIT_AREA | {4'h0, req_i.addr[6:3]});
				is_sfr  = req_i.addr[7];
				bit_pos = req_i.addr[2:0];
			end
			default: is_mem = 1'b0;
		endcase
	end

	always_comb begin
		sfr_val = 8'h00;
		case (eaddr)
			`DMX_SFR_SP:  sfr_val = sp_q;
			`DMX_SFR_DPL: sfr_val = data_pointer_q[7:0];
			`DMX_SFR_DPH: sfr_val = data_pointer_q[15:8];
			`DMX_SFR_P2:  sfr_val = p2_q;
			`DMX_SFR_PSW: sfr_val = {psw_q, par_q};
			`DMX_SFR_ACC: sfr_val = acc_q;
			default:      sfr_val = 8'h00;
		endcase
	end

	// RULE6 same address, two blocks
	// RULE5 three spaces from a byte
	always_comb begin
		if (is_acc) begin
			rd_byte = acc_q;
		end else if (is_sfr) begin
			rd_byte = sfr_val;
		end else if (eaddr[7]) begin
			rd_byte = HAS_UPPER_RAM ? upper_q[eaddr[6:0]] : 8'h00;
		end else begin
			rd_byte = lower_q[eaddr[6:0]];
		end
	end

	assign bit_mask = 8'h01 << bit_pos;
	assign bit_val  = rd_byte[bit_pos];

	always_comb begin
		unique case (req_i.op)
			OP_BIT_SET:   wr_byte = rd_byte | bit_mask;
			OP_BIT_CLR:   wr_byte = rd_byte & ~bit_mask;
			OP_CY_TO_BIT: wr_byte = psw_q[`DMX_PSW_CY] ? (rd_byte | bit_mask)
			                                           : (rd_byte & ~bit_mask);
			default:      wr_byte = req_i.wdata;
		endcase
	end

	assign do_wr  = take && is_mem && ((req_i.op == OP_WRITE) || ((req_i.mode == MD_BIT) &&
	                ((req_i.op == OP_BIT_SET) || (req_i.op == OP_BIT_CLR) ||
	                 (req_i.op == OP_CY_TO_BIT))));
	assign wr_acc = do_wr && (is_acc || (is_sfr && (eaddr == `DMX_SFR_ACC)));
	assign wr_sfr = do_wr && is_sfr;

	// RULE17 carry as bit accumulator
	always_comb begin
		cy_op   = take && (req_i.mode == MD_BIT) && ((req_i.op == OP_BIT_TO_CY) ||
		          (req_i.op == OP_ANL_CY) || (req_i.op == OP_ORL_CY));
		cy_next = bit_val;
		if (req_i.op == OP_ANL_CY) begin
			cy_next = psw_q[`DMX_PSW_CY] & bit_val;
		end else if (req_i.op == OP_ORL_CY) begin
			cy_next = psw_q[`DMX_PSW_CY] | bit_val;
		end
	end

	assign is_x    = (req_i.mode == MD_XRAM_R0) || (req_i.mode == MD_XRAM_R1) ||
	                 (req_i.mode == MD_XRAM_DATA_POINTER);
	assign is_code = (req_i.mode == MD_CODE_DATA_POINTER) || (req_i.mode == MD_CODE_PC) ||
	                 (req_i.mode == MD_JUMP);

	// RULE1 sixteen-bit external space
	always_comb begin
		xreq.start = take && is_x;
		xreq.write = (req_i.op == OP_WRITE);
		xreq.wide  = (req_i.mode == MD_XRAM_DATA_POINTER);
		xreq.addr  = xreq.wide ? data_pointer_q : {8'h00, (req_i.mode == MD_XRAM_R0) ? r0_val : r1_val};
		xreq.wdata = req_i.wdata;
	end

	// RULE15 parity follows accumulator
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			acc_q <= `DMX_ACC_RESET;
			par_q <= ^`DMX_ACC_RESET;
		end else if (wr_acc) begin
			acc_q <= wr_byte;
			par_q <= ^wr_byte;
		end
	end

	// alu flags land last so a hardware update wins over a software write
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			psw_q <= `DMX_PSW_RESET;
		end else begin
			// RULE23 parity never stored
			if (wr_sfr && (eaddr == `DMX_SFR_PSW)) begin
				psw_q <= wr_byte[7:1];
			end
			if (cy_op) begin
				psw_q[`DMX_PSW_CY] <= cy_next;
			end
			if (flags_i.we) begin
				psw_q[`DMX_PSW_CY] <= flags_i.cy;
				psw_q[`DMX_PSW_AC] <= flags_i.ac;
				psw_q[`DMX_PSW_OV] <= flags_i.ov;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			sp_q <= `DMX_SP_RESET;
		end else if (wr_sfr && (eaddr == `DMX_SFR_SP)) begin
			sp_q <= wr_byte;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			data_pointer_q <= `DMX_DATA_POINTER_RESET;
		end else if (wr_sfr && (eaddr == `DMX_SFR_DPL)) begin
			data_pointer_q[7:0] <= wr_byte;
		end else if (wr_sfr && (eaddr == `DMX_SFR_DPH)) begin
			data_pointer_q[15:8] <= wr_byte;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			p2_q <= `DMX_P2_RESET;
		end else if (wr_sfr && (eaddr == `DMX_SFR_P2)) begin
			p2_q <= wr_byte;
		end
	end

	// ram contents are not reset; software must write before it reads
	always_ff @(posedge clock_i) begin
		if (do_wr && !is_acc && !is_sfr && !eaddr[7]) begin
			lower_q[eaddr[6:0]] <= wr_byte;
		end
	end

	always_ff @(posedge clock_i) begin
		if (HAS_UPPER_RAM && do_wr && !is_acc && !is_sfr && eaddr[7]) begin
			upper_q[eaddr[6:0]] <= wr_byte;
		end
	end

	// RULE20 base plus accumulator
	// RULE21 jump target sum
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			code_addr_o <= 16'h0000;
		end else if (take && is_code) begin
			code_addr_o <= ((req_i.mode == MD_CODE_PC) ? program_counter_i : data_pointer_q) +
			               {8'h00, acc_q};
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			ready_o <= 1'b0;
			busy_o  <= 1'b0;
			rdata_o <= 8'h00;
		end else begin
			ready_o <= 1'b0;
			unique case (state_q)
				ST_IDLE: begin
					if (take && is_x) begin
						state_q <= ST_XBUS;
						busy_o  <= 1'b1;
					end else if (take) begin
						ready_o <= 1'b1;
						rdata_o <= (req_i.mode == MD_BIT) ? {7'h00, bit_val} : rd_byte;
					end
				end
				ST_XBUS: begin
					if (x_done) begin
						state_q <= ST_IDLE;
						busy_o  <= 1'b0;
						ready_o <= 1'b1;
						rdata_o <= x_rdata;
					end
				end
			endcase
		end
	end

	dmx_xram_port #(
		.STROBE_CYCLES(STROBE_CYCLES)
	) u_xram (
		.clock_i      (clock_i),
		.rst_i        (rst_i),
		.xreq_i       (xreq),
		.page_i       (p2_q),
		.p0_i         (muxed_addr_data_port_i),
		.done_o       (x_done),
		.rdata_o      (x_rdata),
		.p0_o         (muxed_addr_data_port_o),
		.p0_oe_o      (muxed_addr_data_port_oe_o),
		.addr_latch_o (addr_latch_o),
		.rd_n_o       (read_strobe_n_o),
		.wr_n_o       (write_strobe_n_o),
		.p2_o         (high_address_port_o)
	);

	// checking helpers sampled every cycle, the high address byte only on a take
	logic [6:0]  chk_idx_q;
	logic [7:0]  chk_val_q;
	logic        chk_bit_q;
	logic [7:0]  chk_hi_q;
	always_ff @(posedge clock_i) begin
		chk_idx_q <= eaddr[6:0];
		chk_val_q <= req_i.wdata;
		chk_bit_q <= bit_val;
		if (take) begin
			chk_hi_q <= xreq.wide ? data_pointer_q[15:8] : p2_q;
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	a_parity_even: assert property (status_word_o[0] == ^acc_q) // RULE15
		else $error("parity flag disagrees with accumulator");
	a_parity_write_ignored: assert property ( // RULE23
		take && wr_sfr && (eaddr == `DMX_SFR_PSW) |=> $stable(status_word_o[0]))
		else $error("status word write changed parity");
	a_reg_bank_write: assert property ( // RULE9
		take && (req_i.mode == MD_REG) && (req_i.op == OP_WRITE) |=>
		lower_q[chk_idx_q] == chk_val_q)
		else $error("register write missed its bank slot");
	a_direct_sp_read: assert property ( // RULE13
		take && (req_i.mode == MD_DIRECT) && (req_i.op == OP_READ) &&
		(req_i.addr == `DMX_SFR_SP) |=> ready_o && (rdata_o == sp_q))
		else $error("direct read of stack pointer wrong");
	a_indirect_upper: assert property ( // RULE6
		take && HAS_UPPER_RAM && (req_i.mode == MD_IND_R0) && (req_i.op == OP_WRITE) &&
		r0_val[7] |=> upper_q[chk_idx_q] == chk_val_q)
		else $error("indirect high write missed upper ram");
	a_high_byte_held: assert property ( // RULE2
		(state_q == ST_XBUS) && !(read_strobe_n_o && write_strobe_n_o) |->
		high_address_port_o == chk_hi_q)
		else $error("port two not holding high address");
	a_strobe_width: assert property ( // RULE3
		$fell(read_strobe_n_o) |-> (!read_strobe_n_o)[*4] ##1 read_strobe_n_o)
		else $error("read strobe width wrong");
	a_latch_then_strobe: assert property ( // RULE3
		$rose(addr_latch_o) |-> muxed_addr_data_port_oe_o ##1
		(!addr_latch_o && (read_strobe_n_o != write_strobe_n_o)))
		else $error("strobe did not follow address latch");
	a_code_index: assert property ( // RULE20
		take && (req_i.mode == MD_CODE_DATA_POINTER) |=>
		code_addr_o == ($past(data_pointer_q) + {8'h00, $past(acc_q)}))
		else $error("indexed code address wrong");
	a_bit_to_carry: assert property ( // RULE17
		take && (req_i.mode == MD_BIT) && (req_i.op == OP_BIT_TO_CY) && !flags_i.we |=>
		status_word_o[7] == chk_bit_q)
		else $error("bit not moved into carry");
	a_xram_ready: assert property ( // RULE3
		take && is_x |-> ##7 ready_o)
		else $error("external access answer late");

	c_xram_read:  cover property (take && (req_i.mode == MD_XRAM_DATA_POINTER) && (req_i.op == OP_READ));
	c_xram_write: cover property (take && (req_i.mode == MD_XRAM_R1) && (req_i.op == OP_WRITE));
	c_sfr_bit:    cover property (take && (req_i.mode == MD_BIT) && req_i.addr[7] && do_wr);
	c_upper:      cover property (take && (req_i.mode == MD_IND_SP) && sp_q[7]);
endmodule

// File: logic/dmx_params.svh
// offsets, field positions, reset values and counts of the data memory block
// assumes nothing; included by the package users by bare name
`ifndef DMX_PARAMS_SVH
`define DMX_PARAMS_SVH
`define DMX_LOWER_SIZE    128
`define DMX_UPPER_SIZE    128
`define DMX_BIT_AREA      8'h20
`define DMX_SFR_SP        8'h81
`define DMX_SFR_DPL       8'h82
`define DMX_SFR_DPH       8'h83
`define DMX_SFR_P2        8'ha0
`define DMX_SFR_PSW       8'hd0
`define DMX_SFR_ACC       8'he0
`define DMX_PSW_CY        7
`define DMX_PSW_AC        6
`define DMX_PSW_F0        5
`define DMX_PSW_RS1       4
`define DMX_PSW_RS0       3
`define DMX_PSW_OV        2
`define DMX_PSW_F1        1
`define DMX_PSW_P         0
`define DMX_PSW_RESET     7'h00
`define DMX_SP_RESET      8'h07
`define DMX_DATA_POINTER_RESET    16'h0000
`define DMX_P2_RESET      8'hff
`define DMX_ACC_RESET     8'h00
`define DMX_XRAM_STROBE   4
`endif

// File: logic/dmx_pkg.sv
// types shared by the data memory block and its external memory port
// assumes the params header is compiled alongside
package dmx_pkg;
	typedef enum logic [3:0] {
		MD_DIRECT, MD_IND_R0, MD_IND_R1, MD_IND_SP, MD_REG, MD_ACC, MD_BIT,
		MD_XRAM_R0, MD_XRAM_R1, MD_XRAM_DATA_POINTER, MD_CODE_DATA_POINTER, MD_CODE_PC, MD_JUMP
	} dmx_mode_t;

	typedef enum logic [2:0] {
		OP_READ, OP_WRITE, OP_BIT_SET, OP_BIT_CLR, OP_BIT_TO_CY, OP_CY_TO_BIT,
		OP_ANL_CY, OP_ORL_CY
	} dmx_op_t;

	typedef struct packed {
		dmx_mode_t   mode;
		dmx_op_t     op;
		logic [7:0]  addr;
		logic [7:0]  wdata;
	} dmx_req_t;

	typedef struct packed {
		logic we;
		logic cy;
		logic ac;
		logic ov;
	} dmx_flags_t;

	typedef struct packed {
		logic        start;
		logic        write;
		logic        wide;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} dmx_xreq_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_XBUS = 2'h2
	} dmx_state_t;

	typedef enum logic [3:0] {
		XS_IDLE   = 4'h1,
		XS_ADDR   = 4'h2,
		XS_STROBE = 4'h4,
		XS_DONE   = 4'h8
	} dmx_xstate_t;
endpackage

// File: logic/dmx_xram_port.sv
// external data memory port: address latch phase, then read or write strobe
// assumes an external latch captures the low address while addr_latch_o is high
`timescale 1ns/10ps
`include "dmx_params.svh"
module dmx_xram_port
	import dmx_pkg::*;
#(
	parameter int STROBE_CYCLES = `DMX_XRAM_STROBE
) (
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire dmx_xreq_t  xreq_i,
	input  wire logic [7:0] page_i,
	input  wire logic [7:0] p0_i,
	output logic            done_o,
	output logic [7:0]      rdata_o,
	output logic [7:0]      p0_o,
	output logic            p0_oe_o,
	output logic            addr_latch_o,
	output logic            rd_n_o,
	output logic            wr_n_o,
	output logic [7:0]      p2_o
);
	dmx_xstate_t xstate_q;
	logic [7:0]  p0_meta_q;
	logic [7:0]  p0_sync_q;
	logic [7:0]  cnt_q;
	logic        write_q;
	logic [7:0]  wdata_q;
	logic        wide_q;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			p0_meta_q <= 8'h00;
			p0_sync_q <= 8'h00;
		end else begin
			p0_meta_q <= p0_i;
			p0_sync_q <= p0_meta_q;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			xstate_q     <= XS_IDLE;
			done_o       <= 1'b0;
			rdata_o      <= 8'h00;
			p0_o         <= 8'h00;
			p0_oe_o      <= 1'b0;
			addr_latch_o <= 1'b0;
			rd_n_o       <= 1'b1;
			wr_n_o       <= 1'b1;
			p2_o         <= `DMX_P2_RESET;
			cnt_q        <= 8'h00;
			write_q      <= 1'b0;
			wdata_q      <= 8'h00;
			wide_q       <= 1'b0;
		end else begin
			unique case (xstate_q)
				XS_IDLE: begin
					done_o <= 1'b0;
					// RULE4 paged by latch
					p2_o   <= page_i;
					if (xreq_i.start) begin
						write_q      <= xreq_i.write;
						wdata_q      <= xreq_i.wdata;
						wide_q       <= xreq_i.wide;
						// RULE3 low address phase
						p0_o         <= xreq_i.addr[7:0];
						p0_oe_o      <= 1'b1;
						addr_latch_o <= 1'b1;
						// RULE2 high byte out
						p2_o         <= xreq_i.wide ? xreq_i.addr[15:8] : page_i;
						xstate_q     <= XS_ADDR;
					end
				end
				XS_ADDR: begin
					addr_latch_o <= 1'b0;
					cnt_q        <= 8'(STROBE_CYCLES - 1);
					// RULE3 data phase strobe
					if (write_q) begin
						p0_o   <= wdata_q;
						wr_n_o <= 1'b0;
					end else begin
						p0_oe_o <= 1'b0;
						rd_n_o  <= 1'b0;
					end
					xstate_q <= XS_STROBE;
				end
				XS_STROBE: begin
					if (!wide_q) begin
						p2_o <= page_i;
					end
					if (cnt_q == 8'h00) begin
						rd_n_o   <= 1'b1;
						wr_n_o   <= 1'b1;
						p0_oe_o  <= 1'b0;
						rdata_o  <= p0_sync_q;
						done_o   <= 1'b1;
						xstate_q <= XS_DONE;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				XS_DONE: begin
					done_o   <= 1'b0;
					p2_o     <= page_i;
					xstate_q <= XS_IDLE;
				end
			endcase
		end
	end
endmodule

// File: tb/dmx_data_memory_tb.sv
// self-checking bench for the data memory block and its external RAM port
// assumes requests are taken on rising edges; the bench drives on falling edges
`timescale 1ns/10ps
module dmx_data_memory_tb;
	import dmx_pkg::*;
	logic        clock_i;
	logic        rst_i;
	logic        req_valid_i;
	dmx_req_t    req_i;
	dmx_flags_t  flags_i;
	logic [15:0] pc;
	logic        ready;
	logic        busy;
	logic        oe;
	logic        ale;
	logic        rd_n;
	logic        wr_n;
	logic [7:0]  rdata;
	logic [7:0]  status;
	logic [7:0]  p0_o;
	logic [7:0]  p0_i;
	logic [7:0]  p2;
	logic [7:0]  ram_d;
	logic [15:0] code_addr;
	logic [7:0]  p2_seen;
	int          n_errors;
	int          n_tests;
	int          cycles;
	int          lat;

	dmx_data_memory dut (
		.clock_i(clock_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
		.flags_i(flags_i), .program_counter_i(pc), .ready_o(ready), .busy_o(busy),
		.rdata_o(rdata), .code_addr_o(code_addr), .status_word_o(status),
		.muxed_addr_data_port_o(p0_o), .muxed_addr_data_port_oe_o(oe),
		.muxed_addr_data_port_i(p0_i), .addr_latch_o(ale), .read_strobe_n_o(rd_n),
		.write_strobe_n_o(wr_n), .high_address_port_o(p2)
	);
	dmx_sram_model ram (
		.clock_i(clock_i), .bus_i(p0_i), .latch_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n),
		.high_i(p2), .drive_o(ram_d)
	);
	assign p0_i = oe ? p0_o : ram_d;

	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end

	task automatic tally_and_finish;
		$display("tests=%0d errors=%0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one request, held until the take edge, then wait for the answer
	task automatic op(input dmx_mode_t m, input dmx_op_t o, input logic [7:0] a,
		input logic [7:0] d);
		int k;
		@(negedge clock_i);
		req_valid_i = 1'b1;
		req_i = '{mode: m, op: o, addr: a, wdata: d};
		@(negedge clock_i);
		req_valid_i = 1'b0;
		p2_seen = p2;
		for (k = 1; k < 20 && ready !== 1'b1; k++)
			@(negedge clock_i);
		lat = k;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		op(MD_DIRECT, OP_WRITE, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		op(MD_DIRECT, OP_READ, a, 8'h00);
		chk8(rdata, exp);
	endtask

	task automatic t_reset;
		chk8(status, 8'h00);
		chk8(p2, 8'hff);
		chk8({2'h0, rd_n, wr_n, oe, ale, busy, ready}, 8'h30);
		chk16(code_addr, 16'h0000);
		rd(8'h81, 8'h07);
	endtask

	task automatic t_banks;
		for (int b = 0; b < 4; b++) begin
			wr(8'hd0, 8'(b << 3));
			chk8(status, 8'(b << 3));
			op(MD_REG, OP_WRITE, 8'h00, 8'(8'h40 + b));
			op(MD_REG, OP_WRITE, 8'h07, 8'(8'h50 + b));
		end
		wr(8'hd0, 8'h00);
		for (int b = 0; b < 4; b++) begin
			rd(8'(b * 8), 8'(8'h40 + b));
			rd(8'(b * 8 + 7), 8'(8'h50 + b));
		end
	endtask

	task automatic t_indirect;
		wr(8'hd0, 8'h08);
		op(MD_REG, OP_WRITE, 8'h00, 8'h30);
		op(MD_IND_R0, OP_WRITE, 8'h00, 8'h5a);
		wr(8'hd0, 8'h00);
		rd(8'h30, 8'h5a);
		rd(8'h08, 8'h30);
		wr(8'h01, 8'h90);
		op(MD_IND_R1, OP_WRITE, 8'h00, 8'ha5);
		rd(8'h90, 8'h00);
		wr(8'h90, 8'h77);
		op(MD_IND_R1, OP_READ, 8'h00, 8'h00);
		chk8(rdata, 8'ha5);
		wr(8'h81, 8'h40);
		op(MD_IND_SP, OP_WRITE, 8'h00, 8'h11);
		rd(8'h40, 8'h11);
		wr(8'h81, 8'h07);
	endtask

	task automatic t_bits;
		wr(8'h21, 8'h00);
		wr(8'h20, 8'h00);
		op(MD_BIT, OP_BIT_SET, 8'h0f, 8'h00);
		rd(8'h21, 8'h80);
		op(MD_BIT, OP_READ, 8'h0f, 8'h00);
		chk8(rdata, 8'h01);
		op(MD_BIT, OP_BIT_TO_CY, 8'h0f, 8'h00);
		chk8(status, 8'h80);
		op(MD_BIT, OP_CY_TO_BIT, 8'h00, 8'h00);
		rd(8'h20, 8'h01);
		op(MD_BIT, OP_BIT_CLR, 8'h0f, 8'h00);
		op(MD_BIT, OP_ANL_CY, 8'h0f, 8'h00);
		chk8(status, 8'h00);
		op(MD_BIT, OP_ORL_CY, 8'h00, 8'h00);
		chk8(status, 8'h80);
		wr(8'he0, 8'h00);
		op(MD_BIT, OP_BIT_SET, 8'he3, 8'h00);
		rd(8'he0, 8'h08);
		chk8(status, 8'h81);
		wr(8'he0, 8'h00);
		wr(8'hd0, 8'h00);
	endtask

	task automatic t_status;
		logic [7:0] vals [6] = '{8'h00, 8'h01, 8'h03, 8'h80, 8'hff, 8'h7e};
		foreach (vals[i]) begin
			op(MD_ACC, OP_WRITE, 8'h00, vals[i]);
			chk8(status, {7'h00, ^vals[i]});
			rd(8'he0, vals[i]);
		end
		wr(8'hd0, 8'h01);
		chk8(status, 8'h00);
		wr(8'hd0, 8'hfe);
		chk8(status, 8'hfe);
		@(negedge clock_i);
		flags_i = '{we: 1'b1, cy: 1'b1, ac: 1'b0, ov: 1'b1};
		@(negedge clock_i);
		flags_i = '0;
		chk8(status, 8'hbe);
		wr(8'hd0, 8'h00);
	endtask

	task automatic t_code;
		wr(8'h82, 8'h34);
		wr(8'h83, 8'h12);
		op(MD_ACC, OP_WRITE, 8'h00, 8'h10);
		pc = 16'hfff8;
		op(MD_CODE_DATA_POINTER, OP_READ, 8'h00, 8'h00);
		chk16(code_addr, 16'h1244);
		op(MD_CODE_PC, OP_READ, 8'h00, 8'h00);
		chk16(code_addr, 16'h0008);
		op(MD_JUMP, OP_READ, 8'h00, 8'h00);
		chk16(code_addr, 16'h1244);
	endtask

	task automatic t_xram;
		wr(8'h82, 8'h12);
		wr(8'h83, 8'hbe);
		op(MD_XRAM_DATA_POINTER, OP_WRITE, 8'h00, 8'hc3);
		chk8(8'(lat), 8'h07);
		chk8(p2_seen, 8'hbe);
		chk8(ram.mem[16'hbe12], 8'hc3);
		op(MD_XRAM_DATA_POINTER, OP_READ, 8'h00, 8'h00);
		chk8(rdata, 8'hc3);
		chk8(p2, 8'hff);
		wr(8'h82, 8'hff);
		wr(8'h83, 8'hff);
		op(MD_XRAM_DATA_POINTER, OP_WRITE, 8'h00, 8'h3c);
		chk8(ram.mem[16'hffff], 8'h3c);
		wr(8'ha0, 8'h05);
		wr(8'h00, 8'h34);
		wr(8'h01, 8'h34);
		op(MD_XRAM_R0, OP_WRITE, 8'h00, 8'h77);
		chk8(p2_seen, 8'h05);
		chk8(ram.mem[16'h0534], 8'h77);
		op(MD_XRAM_R1, OP_READ, 8'h00, 8'h00);
		chk8(rdata, 8'h77);
		chk8(p2, 8'h05);
	endtask

	initial begin
		n_errors = 0;
		n_tests = 0;
		cycles = 0;
		rst_i = 1'b1;
		req_valid_i = 1'b0;
		req_i = '0;
		flags_i = '0;
		pc = 16'h0000;
		repeat (8) @(posedge clock_i);
		@(negedge clock_i);
		rst_i = 1'b0;
		t_reset();
		t_banks();
		t_indirect();
		t_bits();
		t_status();
		t_code();
		t_xram();
		tally_and_finish();
	end
endmodule

// File: tb/dmx_sram_model.sv
// behavioural external static RAM with its low address latch
// assumes port zero is resolved by the bench from the block's and this model's drivers
`timescale 1ns/10ps
module dmx_sram_model #(
	parameter int LAG = 0
) (
	input  wire logic       clock_i,
	input  wire logic [7:0] bus_i,
	input  wire logic       latch_i,
	input  wire logic       rd_n_i,
	input  wire logic       wr_n_i,
	input  wire logic [7:0] high_i,
	output logic [7:0]      drive_o
);
	logic [7:0] mem [0:65535];
	logic [7:0] low_q;
	logic [7:0] last_q;
	int         wait_q;
	initial last_q = 8'h5a;
	always @(posedge clock_i) begin
		if (latch_i)
			low_q <= bus_i;
		wait_q <= rd_n_i ? 0 : wait_q + 1;
		if (!wr_n_i)
			mem[{high_i, low_q}] <= bus_i;
		if (!rd_n_i)
			last_q <= drive_o;
	end
	// a released bus shows the inverse of the last value, not a stale copy
	assign drive_o = (!rd_n_i && wait_q >= LAG) ? mem[{high_i, low_q}] : ~last_q;
endmodule
